/* File: rtl/io_ports_pkg.sv */
// constants, register map and types for the parallel port block
package io_ports_pkg;
  localparam logic [3:0] ADDR_P1_DATA = 4'h0;
  localparam logic [3:0] ADDR_P1_DIR = 4'h1;
  localparam logic [3:0] ADDR_P2_DATA = 4'h2;
  localparam logic [3:0] ADDR_P2_DIR = 4'h3;
  localparam logic [3:0] ADDR_P3_DATA = 4'h4;
  localparam logic [3:0] ADDR_PORT_CONFIG = 4'h5;
  localparam logic [3:0] ADDR_P3_MODE = 4'h6;
  localparam logic [3:0] ADDR_IRQ_CFG = 4'h7;
  localparam logic [3:0] ADDR_TIMER_CTRL_0 = 4'h8;
  localparam logic [3:0] ADDR_TIMER_CTRL_1 = 4'h9;
  localparam logic [3:0] ADDR_TIMER_CTRL_2 = 4'hA;
  localparam logic [3:0] ADDR_INT_STATUS = 4'hB;
  localparam logic [3:0] ADDR_INT_MASK = 4'hC;
  localparam logic [3:0] ADDR_WAKE = 4'hD;
  // port config fields
  localparam int PCFG_P2_OD = 0;
  localparam int PCFG_P1_OD = 1;
  localparam int PCFG_CMP1_P34 = 2;
  localparam int PCFG_CMP2_P37 = 3;
  // port 3 mode field
  localparam int P3M_ANALOG = 1;
  // irq config fields
  localparam int IRQC_EDGE_LO = 6;
  localparam int IRQC_EDGE_HI = 7;
  // timer control fields
  localparam int TC0_P34_T8 = 0;
  localparam int TC1_DEMOD = 7;
  localparam int TC1_DEMOD_SRC = 6;
  localparam int TC1_SEL_LO = 4;
  localparam int TC1_SEL_HI = 5;
  localparam int TC2_P35_T16 = 0;
  // interrupt status bits
  localparam int IS_INT_REQ_0 = 0;
  localparam int IS_INT_REQ_1 = 1;
  localparam int IS_INT_REQ_2 = 2;
  localparam int IS_DEMOD = 3;
  localparam int IS_SMR = 4;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hFF;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef struct packed {
    logic [7:0] p1_out;
    logic [7:0] p1_dir;
    logic [7:0] p2_out;
    logic [7:0] p2_dir;
    logic [3:0] p3_out;
    logic [7:0] pcfg;
    logic [7:0] p3_mode;
    logic [7:0] irq_cfg;
    logic [7:0] tc0;
    logic [7:0] tc1;
    logic [7:0] tc2;
    logic [4:0] int_stat;
    logic [4:0] int_mask;
    logic [7:0] p1_s1;
    logic [7:0] p1_s2;
    logic [7:0] p2_s1;
    logic [7:0] p2_s2;
    logic [3:0] p3_s1;
    logic [3:0] p3_s2;
    logic [3:0] p3_prev;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [1:0] cmp_prev;
    logic demod_prev;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    logic demod_edge;
    logic [7:0] p1_oe;
    logic [7:0] p1_o;
    logic [7:0] p2_oe;
    logic [7:0] p2_o;
    logic [3:0] p3_o;
  } state_s;
endpackage

/* File: rtl/io_ports.sv */
// parallel port block: ports 1, 2 and 3 with comparator routing and interrupts
// Functional notes
// - power-on reset makes port 1 all inputs
// - port 1 push-pull or open-drain by one bit
// - stop recovery returns port 1 to input
// - unbonded port 1 ignores writes, reads FF
// - each port 2 bit has its own direction
// - one global open-drain select for port 2
// - power-on reset makes port 2 all inputs
// - port 2 OR and AND wake-up terms
// - demod edge input from port 2 bit 0 or port3 in1
// - port 3: four fixed inputs, four push-pull outputs
// - mode bit 1 selects comparators on in1/in2
// - in1/in2 interrupt edge chosen by bits 6,7
// - analog mode routes in3 to stop recovery
// - digital mode: in3 is D3 and int_req_1
// - stop mode powers comparators down
// - port 3 outputs out4 to out6 select timer or logic outputs; out7 has only the latch or comparator 2
// - comparator results routable to out4 and out7
// - port reads return sampled pin levels, except comparator results on in1/in2 and 0 on in3 in analog mode; port 3 output bits read back the output latch
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module io_ports
  import io_ports_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic por_i,
  input wire logic stop_recovery_i,
  input wire logic stop_mode_i,
  input wire logic p1_bonded_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] p1_pin_i,
  output logic [7:0] p1_pin_o,
  output logic [7:0] p1_pin_oe_o,
  input wire logic [7:0] p2_pin_i,
  output logic [7:0] p2_pin_o,
  output logic [7:0] p2_pin_oe_o,
  input wire logic [3:0] p3_pin_i,
  input wire logic [1:0] cmp_raw_i,
  input wire logic t8_out_i,
  input wire logic t16_out_i,
  input wire logic logic_out_i,
  output logic [3:0] p3_pin_o,
  output logic cmp_power_o,
  output logic demod_edge_o,
  output logic wake_o,
  output logic irq_o
);
  import io_ports_pkg::*;

  state_s q_ff, nxt_q;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    case (sel)
      EDGE_FALL: edge_hit = prev & ~cur;
      EDGE_RISE: edge_hit = ~prev & cur;
      EDGE_BOTH: edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  logic analog;
  logic [1:0] in12;
  logic [4:0] ev;
  logic dm_src;
  logic [7:0] rd_val;

  always_comb begin
    analog = q_ff.p3_mode[P3M_ANALOG] & ~stop_mode_i;
    in12 = analog ? q_ff.cmp_s2 : q_ff.p3_s2[2:1];
    dm_src = q_ff.tc1[TC1_DEMOD_SRC] ? q_ff.p2_s2[0] : in12[0];
    ev = '0;
    // in2 -> int_req_0, in3 -> int_req_1, in1 -> int_req_2
    ev[IS_INT_REQ_0] = edge_hit(q_ff.irq_cfg[IRQC_EDGE_HI:IRQC_EDGE_LO], q_ff.cmp_prev[1], in12[1]);
    ev[IS_INT_REQ_2] = edge_hit(q_ff.irq_cfg[IRQC_EDGE_HI:IRQC_EDGE_LO], q_ff.cmp_prev[0], in12[0]);
    ev[IS_INT_REQ_1] = ~analog & q_ff.p3_prev[3] & ~q_ff.p3_s2[3];
    ev[IS_SMR] = analog & q_ff.p3_prev[3] & ~q_ff.p3_s2[3];
    ev[IS_DEMOD] = q_ff.tc1[TC1_DEMOD] &
      edge_hit(q_ff.tc1[TC1_SEL_HI:TC1_SEL_LO], q_ff.demod_prev, dm_src);
  end

  always_comb begin
    case (addr_i)
      ADDR_P1_DATA: rd_val = p1_bonded_i ? q_ff.p1_s2 : RST_ONES;
      ADDR_P1_DIR: rd_val = q_ff.p1_dir;
      ADDR_P2_DATA: rd_val = q_ff.p2_s2;
      ADDR_P2_DIR: rd_val = q_ff.p2_dir;
      ADDR_P3_DATA: rd_val = {q_ff.p3_out, analog ? 1'b0 : q_ff.p3_s2[3], in12, q_ff.p3_s2[0]};
      ADDR_PORT_CONFIG: rd_val = q_ff.pcfg;
      ADDR_P3_MODE: rd_val = q_ff.p3_mode;
      ADDR_IRQ_CFG: rd_val = q_ff.irq_cfg;
      ADDR_TIMER_CTRL_0: rd_val = q_ff.tc0;
      ADDR_TIMER_CTRL_1: rd_val = q_ff.tc1;
      ADDR_TIMER_CTRL_2: rd_val = q_ff.tc2;
      ADDR_INT_STATUS: rd_val = {3'h0, q_ff.int_stat};
      ADDR_INT_MASK: rd_val = {3'h0, q_ff.int_mask};
      ADDR_WAKE: rd_val = {6'h00, &q_ff.p2_s2, |q_ff.p2_s2};
      default: rd_val = RST_ZERO;
    endcase
  end

  always_comb begin
    nxt_q = q_ff;
    // two-stage synchronisers; only stage two feeds logic
    nxt_q.p1_s1 = p1_pin_i;
    nxt_q.p1_s2 = q_ff.p1_s1;
    nxt_q.p2_s1 = p2_pin_i;
    nxt_q.p2_s2 = q_ff.p2_s1;
    nxt_q.p3_s1 = p3_pin_i;
    nxt_q.p3_s2 = q_ff.p3_s1;
    nxt_q.cmp_s1 = cmp_raw_i;
    nxt_q.cmp_s2 = q_ff.cmp_s1;
    nxt_q.p3_prev = q_ff.p3_s2;
    nxt_q.cmp_prev = in12;
    nxt_q.demod_prev = dm_src;
    nxt_q.rdata = rd_i ? rd_val : RST_ZERO;
    if (wr_i) begin
      case (addr_i)
        ADDR_P1_DATA: if (p1_bonded_i) nxt_q.p1_out = wdata_i;
        ADDR_P1_DIR: nxt_q.p1_dir = wdata_i;
        ADDR_P2_DATA: nxt_q.p2_out = wdata_i;
        ADDR_P2_DIR: nxt_q.p2_dir = wdata_i;
        ADDR_P3_DATA: nxt_q.p3_out = wdata_i[7:4];
        ADDR_PORT_CONFIG: nxt_q.pcfg = wdata_i;
        ADDR_P3_MODE: nxt_q.p3_mode = wdata_i;
        ADDR_IRQ_CFG: nxt_q.irq_cfg = wdata_i;
        ADDR_TIMER_CTRL_0: nxt_q.tc0 = wdata_i;
        ADDR_TIMER_CTRL_1: nxt_q.tc1 = wdata_i;
        ADDR_TIMER_CTRL_2: nxt_q.tc2 = wdata_i;
        ADDR_INT_MASK: nxt_q.int_mask = wdata_i[4:0];
        default: ;
      endcase
    end
    // write-one-to-clear; a same-cycle event wins
    if (wr_i && addr_i == ADDR_INT_STATUS) begin
      nxt_q.int_stat = q_ff.int_stat & ~wdata_i[4:0];
    end
    nxt_q.int_stat = nxt_q.int_stat | ev;
    // stop recovery returns port 1 to input, other state kept
    if (stop_recovery_i) begin
      nxt_q.p1_dir = RST_ZERO;
    end
    nxt_q.irq = |(nxt_q.int_stat & nxt_q.int_mask);
    nxt_q.wake = (|q_ff.p2_s2) | (&q_ff.p2_s2) | ev[IS_SMR];
    nxt_q.demod_edge = ev[IS_DEMOD];
    // open-drain drives only low; push-pull drives both levels
    for (int i = 0; i < 8; i++) begin
      nxt_q.p1_oe[i] = nxt_q.p1_dir[i] & (~nxt_q.pcfg[PCFG_P1_OD] | ~nxt_q.p1_out[i]);
      nxt_q.p2_oe[i] = nxt_q.p2_dir[i] & (~nxt_q.pcfg[PCFG_P2_OD] | ~nxt_q.p2_out[i]);
    end
    nxt_q.p1_o = nxt_q.p1_out;
    nxt_q.p2_o = nxt_q.p2_out;
    // port 3 outputs always driven (push-pull, no direction)
    nxt_q.p3_o[0] = nxt_q.pcfg[PCFG_CMP1_P34] ? in12[0] :
      (nxt_q.tc0[TC0_P34_T8] ? t8_out_i : nxt_q.p3_out[0]);
    nxt_q.p3_o[1] = nxt_q.tc2[TC2_P35_T16] ? t16_out_i : nxt_q.p3_out[1];
    nxt_q.p3_o[2] = (~nxt_q.tc1[TC1_DEMOD] & nxt_q.tc1[TC1_DEMOD_SRC]) ? logic_out_i : nxt_q.p3_out[2];
    nxt_q.p3_o[3] = nxt_q.pcfg[PCFG_CMP2_P37] ? in12[1] : nxt_q.p3_out[3];
    if (srst_i || por_i) begin
      nxt_q = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    q_ff <= nxt_q;
  end

  always_ff @(posedge clk_sys_i) begin
    rdata_o <= nxt_q.rdata;
    p1_pin_o <= nxt_q.p1_o;
    p1_pin_oe_o <= nxt_q.p1_oe;
    p2_pin_o <= nxt_q.p2_o;
    p2_pin_oe_o <= nxt_q.p2_oe;
    p3_pin_o <= nxt_q.p3_o;
    cmp_power_o <= ~(srst_i | por_i) & ~stop_mode_i & nxt_q.p3_mode[P3M_ANALOG];
    demod_edge_o <= nxt_q.demod_edge;
    wake_o <= nxt_q.wake;
    irq_o <= nxt_q.irq;
  end

  property p_p1_input_after_por;
    @(posedge clk_sys_i) por_i |=> (p1_pin_oe_o == 8'h00);
  endproperty
  a_p1_input_after_por: assert property (p_p1_input_after_por) else $error("port 1 drives after reset");

  property p_p2_input_after_por;
    @(posedge clk_sys_i) por_i |=> (p2_pin_oe_o == 8'h00);
  endproperty
  a_p2_input_after_por: assert property (p_p2_input_after_por) else $error("port 2 drives after reset");

  property p_p1_smr_input;
    @(posedge clk_sys_i) disable iff (srst_i) stop_recovery_i |=> (q_ff.p1_dir == 8'h00);
  endproperty
  a_p1_smr_input: assert property (p_p1_smr_input) else $error("port 1 not input after recovery");

  property p_p1_unbonded_ff;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rd_i && !p1_bonded_i && addr_i == ADDR_P1_DATA) |=> (rdata_o == 8'hFF);
  endproperty
  a_p1_unbonded_ff: assert property (p_p1_unbonded_ff) else $error("unbonded port 1 read not FF");

  property p_p1_od_high;
    @(posedge clk_sys_i) disable iff (srst_i)
      (q_ff.pcfg[PCFG_P1_OD] && q_ff.p1_out[0]) |-> !p1_pin_oe_o[0];
  endproperty
  a_p1_od_high: assert property (p_p1_od_high) else $error("open-drain port 1 drives high");

  property p_p2_od_high;
    @(posedge clk_sys_i) disable iff (srst_i)
      (q_ff.pcfg[PCFG_P2_OD] && q_ff.p2_out[3]) |-> !p2_pin_oe_o[3];
  endproperty
  a_p2_od_high: assert property (p_p2_od_high) else $error("open-drain port 2 drives high");

  property p_p2_dir;
    @(posedge clk_sys_i) disable iff (srst_i) !q_ff.p2_dir[5] |-> !p2_pin_oe_o[5];
  endproperty
  a_p2_dir: assert property (p_p2_dir) else $error("input bit of port 2 driven");

  property p_read_pins;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rd_i && addr_i == ADDR_P2_DATA) |=> (rdata_o == $past(q_ff.p2_s2));
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("port 2 read not pin level");

  property p_irq_sticky;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (ev[IS_INT_REQ_1] && q_ff.int_mask[IS_INT_REQ_1]) |=> ##1 irq_o;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("masked-in event gave no interrupt");

  property p_cmp_off_stop;
    @(posedge clk_sys_i) stop_mode_i |=> !cmp_power_o;
  endproperty
  a_cmp_off_stop: assert property (p_cmp_off_stop) else $error("comparators powered in stop");

  // the pin registers load from the next state, so they agree with q_ff at every sample point
  property p_cmp_power_mode;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) cmp_power_o |-> q_ff.p3_mode[P3M_ANALOG];
  endproperty
  a_cmp_power_mode: assert property (p_cmp_power_mode) else $error("comparators powered in digital mode");

  property p_p1_push_pull;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (q_ff.p1_dir[7] && !q_ff.pcfg[PCFG_P1_OD]) |-> p1_pin_oe_o[7];
  endproperty
  a_p1_push_pull: assert property (p_p1_push_pull) else $error("push-pull port 1 output not driven");

  property p_p2_push_pull;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (q_ff.p2_dir[0] && !q_ff.pcfg[PCFG_P2_OD]) |-> p2_pin_oe_o[0];
  endproperty
  a_p2_push_pull: assert property (p_p2_push_pull) else $error("push-pull port 2 output not driven");

  property p_p2_level;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) p2_pin_o == q_ff.p2_out;
  endproperty
  a_p2_level: assert property (p_p2_level) else $error("port 2 level differs from latch");

  property p_p1_unbonded_hold;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (wr_i && !p1_bonded_i && addr_i == ADDR_P1_DATA) |=> (q_ff.p1_out == $past(q_ff.p1_out));
  endproperty
  a_p1_unbonded_hold: assert property (p_p1_unbonded_hold) else $error("unbonded port 1 write landed");

  property p_p1_read_pins;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (rd_i && p1_bonded_i && addr_i == ADDR_P1_DATA) |=> (rdata_o == $past(q_ff.p1_s2));
  endproperty
  a_p1_read_pins: assert property (p_p1_read_pins) else $error("port 1 read not pin level");

  property p_rdata_idle;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) !rd_i |=> (rdata_o == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  property p_wake_or;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) (|q_ff.p2_s2) |=> wake_o;
  endproperty
  a_wake_or: assert property (p_wake_or) else $error("port 2 level gave no wake");

  property p_demod_off;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) !$past(q_ff.tc1[TC1_DEMOD]) |-> !demod_edge_o;
  endproperty
  a_demod_off: assert property (p_demod_off) else $error("edge pulse outside demod mode");

  property p_in3_analog_read;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (rd_i && analog && addr_i == ADDR_P3_DATA) |=> !rdata_o[3];
  endproperty
  a_in3_analog_read: assert property (p_in3_analog_read) else $error("in3 visible in analog mode");

  property p_int_req_1_digital;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (!q_ff.p3_mode[P3M_ANALOG] && q_ff.p3_prev[3] && !q_ff.p3_s2[3]) |=> q_ff.int_stat[IS_INT_REQ_1];
  endproperty
  a_int_req_1_digital: assert property (p_int_req_1_digital) else $error("in3 fall gave no int_req_1");

  property p_int_req_0_set_wins;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) ev[IS_INT_REQ_0] |=> q_ff.int_stat[IS_INT_REQ_0];
  endproperty
  a_int_req_0_set_wins: assert property (p_int_req_0_set_wins) else $error("in2 edge lost");

  property p_irq_level;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) irq_o == |(q_ff.int_stat & q_ff.int_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_out4_t8;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (q_ff.tc0[TC0_P34_T8] && !q_ff.pcfg[PCFG_CMP1_P34]) |-> (p3_pin_o[0] == $past(t8_out_i));
  endproperty
  a_out4_t8: assert property (p_out4_t8) else $error("out4 not timer output");

  property p_out5_t16;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) q_ff.tc2[TC2_P35_T16] |-> (p3_pin_o[1] == $past(t16_out_i));
  endproperty
  a_out5_t16: assert property (p_out5_t16) else $error("out5 not timer output");

  property p_out6_logic;
    @(posedge clk_sys_i) disable iff (srst_i || por_i)
      (!q_ff.tc1[TC1_DEMOD] && q_ff.tc1[TC1_DEMOD_SRC]) |-> (p3_pin_o[2] == $past(logic_out_i));
  endproperty
  a_out6_logic: assert property (p_out6_logic) else $error("out6 not logic output");

  property p_out4_cmp;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) q_ff.pcfg[PCFG_CMP1_P34] |-> (p3_pin_o[0] == $past(in12[0]));
  endproperty
  a_out4_cmp: assert property (p_out4_cmp) else $error("out4 not comparator 1");

  property p_out7_cmp;
    @(posedge clk_sys_i) disable iff (srst_i || por_i) q_ff.pcfg[PCFG_CMP2_P37] |-> (p3_pin_o[3] == $past(in12[1]));
  endproperty
  a_out7_cmp: assert property (p_out7_cmp) else $error("out7 not comparator 2");

  c_demod_edge: cover property (@(posedge clk_sys_i) demod_edge_o);
  c_wake: cover property (@(posedge clk_sys_i) wake_o);
  c_irq: cover property (@(posedge clk_sys_i) irq_o ##1 !irq_o);
  c_smr_event: cover property (@(posedge clk_sys_i) ev[IS_SMR]);
  c_unbonded_read: cover property (@(posedge clk_sys_i) rd_i && !p1_bonded_i && addr_i == ADDR_P1_DATA);
endmodule

/* File: tb/pin_model.sv */
// pin level model: driven bits follow the block, released bits the outside level
`timescale 1ns/1ps
module pin_model (
  input wire logic [7:0] p1_o_i,
  input wire logic [7:0] p1_oe_i,
  input wire logic [7:0] p2_o_i,
  input wire logic [7:0] p2_oe_i,
  input wire logic [7:0] ext1_i,
  input wire logic [7:0] ext2_i,
  output logic [7:0] p1_lvl_o,
  output logic [7:0] p2_lvl_o
);
  // a released bit must not echo the last driven value, so the outside level wins
  assign p1_lvl_o = (p1_oe_i & p1_o_i) | (~p1_oe_i & ext1_i);
  assign p2_lvl_o = (p2_oe_i & p2_o_i) | (~p2_oe_i & ext2_i);
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the parallel port block
`timescale 1ns/1ps
module testbench;
  import io_ports_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic stop_rec = 1'b0, stop_mode = 1'b0, bonded = 1'b1, wr = 1'b0, rd = 1'b0, t8 = 1'b0;
  logic [3:0] addr = 4'h0, p3_in = 4'hF, p3_o;
  logic [7:0] wdata = 8'h00, ext1 = 8'hFF, ext2 = 8'hFF;
  logic [1:0] cmp = 2'h0;
  logic [7:0] rdata, p1_o, p1_oe, p2_o, p2_oe, p1_lvl, p2_lvl;
  logic cmp_pwr, wake, irq, dem, por = 1'b0;
  int hits = 0;
  logic [7:0] e;
  int miscompares = 0;
  int compares = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  pin_model i_pins (.p1_o_i(p1_o), .p1_oe_i(p1_oe), .p2_o_i(p2_o), .p2_oe_i(p2_oe), .ext1_i(ext1),
    .ext2_i(ext2), .p1_lvl_o(p1_lvl), .p2_lvl_o(p2_lvl));
  io_ports i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .por_i(por), .stop_recovery_i(stop_rec),
    .stop_mode_i(stop_mode), .p1_bonded_i(bonded), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .p1_pin_i(p1_lvl), .p1_pin_o(p1_o), .p1_pin_oe_o(p1_oe), .p2_pin_i(p2_lvl),
    .p2_pin_o(p2_o), .p2_pin_oe_o(p2_oe), .p3_pin_i(p3_in), .cmp_raw_i(cmp), .t8_out_i(t8),
    .t16_out_i(1'b0), .logic_out_i(1'b0), .p3_pin_o(p3_o), .cmp_power_o(cmp_pwr), .demod_edge_o(dem),
    .wake_o(wake), .irq_o(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look just past that edge
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    idle(20000);
    miscompares++;
    report_and_stop();
  end
  initial begin
    idle(12);
    srst_i <= 1'b0;
    idle(2);
    #1;
    chk(p1_oe, 8'h00);
    chk(p2_oe, 8'h00);
    rd_reg(ADDR_P1_DIR, 8'h00);
    rd_reg(ADDR_P2_DIR, 8'h00);
    tend("reset");
    for (int i = 0; i < 3; i++) begin
      e = (i == 0) ? 8'hFF : ((i == 1) ? 8'h01 : 8'h00);
      ext2 <= e;
      idle(4);
      rd_reg(ADDR_WAKE, {6'h0, &e, |e});
      chk({7'h0, wake}, {7'h0, |e});
    end
    tend("wake");
    ext2 <= 8'hA5;
    wr_reg(ADDR_P2_DATA, 8'h3C);
    wr_reg(ADDR_P2_DIR, 8'h0F);
    idle(4);
    #1;
    chk(p2_oe, 8'h0F);
    rd_reg(ADDR_P2_DATA, 8'hAC);
    wr_reg(ADDR_PORT_CONFIG, 8'h01);
    idle(3);
    #1;
    chk(p2_oe, 8'h03);
    wr_reg(ADDR_P1_DATA, 8'h0F);
    wr_reg(ADDR_P1_DIR, 8'hFF);
    wr_reg(ADDR_PORT_CONFIG, 8'h02);
    idle(3);
    #1;
    chk(p1_oe, 8'hF0);
    chk(p2_oe, 8'h0F);
    stop_rec <= 1'b1;
    idle(1);
    stop_rec <= 1'b0;
    idle(3);
    #1;
    chk(p1_oe, 8'h00);
    rd_reg(ADDR_P1_DIR, 8'h00);
    bonded <= 1'b0;
    wr_reg(ADDR_P1_DATA, 8'h55);
    rd_reg(ADDR_P1_DATA, 8'hFF);
    chk(p1_o, 8'h0F);
    bonded <= 1'b1;
    wr_reg(ADDR_PORT_CONFIG, 8'h00);
    wr_reg(ADDR_P2_DIR, 8'h00);
    tend("ports 1 and 2");
    wr_reg(ADDR_INT_MASK, 8'h07);
    for (int m = 0; m < 3; m++) begin
      wr_reg(ADDR_IRQ_CFG, {m[1:0], 6'h00});
      wr_reg(ADDR_INT_STATUS, 8'h1F);
      p3_in <= 4'h9;
      idle(6);
      e = (m != 1) ? 8'h05 : 8'h00;
      rd_reg(ADDR_INT_STATUS, e);
      chk({7'h0, irq}, {7'h0, |e});
      wr_reg(ADDR_INT_STATUS, 8'h05);
      p3_in <= 4'hF;
      idle(6);
      e = (m != 0) ? 8'h05 : 8'h00;
      rd_reg(ADDR_INT_STATUS, e);
      chk({7'h0, irq}, {7'h0, |e});
      wr_reg(ADDR_INT_STATUS, 8'h05);
      idle(3);
      #1;
      chk({7'h0, irq}, 8'h00);
    end
    wr_reg(ADDR_INT_MASK, 8'h00);
    p3_in <= 4'h7;
    idle(6);
    rd_reg(ADDR_INT_STATUS, 8'h02);
    rd_reg(ADDR_P3_DATA, 8'h07);
    chk({7'h0, irq}, 8'h00);
    wr_reg(ADDR_INT_STATUS, 8'h1F);
    p3_in <= 4'hF;
    tend("interrupts");
    wr_reg(ADDR_P3_MODE, 8'h02);
    wr_reg(ADDR_PORT_CONFIG, 8'h08);
    cmp <= 2'h2;
    idle(5);
    #1;
    chk({7'h0, cmp_pwr}, 8'h01);
    chk({7'h0, p3_o[3]}, 8'h01);
    cmp <= 2'h0;
    stop_mode <= 1'b1;
    idle(5);
    #1;
    // in stop the comparator path falls back to the in2 pin, which stays high
    chk({7'h0, p3_o[3]}, 8'h01);
    chk({7'h0, cmp_pwr}, 8'h00);
    stop_mode <= 1'b0;
    wr_reg(ADDR_TIMER_CTRL_0, 8'h01);
    t8 <= 1'b1;
    idle(4);
    #1;
    chk({7'h0, p3_o[0]}, 8'h01);
    tend("port 3 outputs");
    wr_reg(ADDR_TIMER_CTRL_1, 8'hD0);
    ext2 <= 8'hA4;
    idle(4);
    wr_reg(ADDR_INT_STATUS, 8'h1F);
    ext2 <= 8'hA5;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      #1;
      hits += dem;
    end
    chk(hits[7:0], 8'h01);
    p3_in <= 4'h7;
    idle(6);
    rd_reg(ADDR_INT_STATUS, 8'h18);
    tend("demod and recovery source");
    wr_reg(ADDR_P1_DIR, 8'hFF);
    wr_reg(ADDR_P2_DIR, 8'hFF);
    por <= 1'b1;
    idle(1);
    por <= 1'b0;
    idle(2);
    #1;
    chk(p1_oe, 8'h00);
    chk(p2_oe, 8'h00);
    rd_reg(ADDR_P2_DIR, 8'h00);
    tend("power-on reset");
    report_and_stop();
  end
endmodule
